// [senp_top.sv]
// emergency reporting, node address selection and identity exposure
// assumes switches and fault strobes are asynchronous pins; register port
// and nonvolatile data come from logic on the same clock
`timescale 1ns/10ps
module senp_top
    import senp_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // node address switches (pins)
    input wire logic [7:0] node_sw_i,
    // fault report from the drive (pins)
    input wire logic fault_stb_i,
    input wire logic fault_is_comm_i,
    input wire logic [7:0] fault_num_i,
    input wire logic [7:0] err_reg_i,
    // nonvolatile slave information
    input wire logic [15:0] nv_alias_i,
    input wire logic [15:0] nv_magic_i,
    input wire logic [31:0] nv_serial_i,
    input wire logic nv_valid_i,
    // register port from the master side
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // diagnosis flags sub-entry written by the master
    input wire logic diag_wr_i,
    input wire logic [7:0] diag_wdata_i,
    // mailbox byte stream
    output logic [7:0] mb_data_o,
    output logic mb_valid_o,
    output logic mb_last_o,
    input wire logic mb_ready_i,
    // status outputs
    output logic [15:0] err_status_o,
    output logic [31:0] serial_o,
    output logic sw_setup_o,
    output logic [15:0] node_addr_o,
    output logic sii_err_o,
    output logic emcy_drop_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] sw_s1_r, sw_s2_r;
    logic [9:0] flt_s1_r, flt_s2_r;
    logic stb_d_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sw_s1_r <= 8'h00;
            sw_s2_r <= 8'h00;
            flt_s1_r <= 10'h000;
            flt_s2_r <= 10'h000;
            stb_d_r <= 1'b0;
        end else begin
            sw_s1_r <= node_sw_i;
            sw_s2_r <= sw_s1_r;
            flt_s1_r <= {fault_stb_i, fault_is_comm_i, fault_num_i};
            flt_s2_r <= flt_s1_r;
            stb_d_r <= flt_s2_r[9];
        end
    end
    wire fault_rise = flt_s2_r[9] && !stb_d_r;
    wire fault_comm = flt_s2_r[8];
    wire [7:0] fault_num = flt_s2_r[7:0];

    // ------------------------------------------------------------
    // power-on capture
    // ------------------------------------------------------------
    // straps are caught once, three cycles after release, so the switch
    // value has passed the synchroniser; later switch moves are ignored
    logic [1:0] boot_cnt_r;
    logic booted_r;
    logic sw_setup_r;
    logic [15:0] alias_r;
    logic [15:0] node_addr_r;
    logic sii_err_r;
    logic [31:0] serial_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            boot_cnt_r <= 2'h0;
            booted_r <= 1'b0;
            sw_setup_r <= 1'b0;
            alias_r <= 16'h0000;
            node_addr_r <= 16'h0000;
            sii_err_r <= 1'b0;
            serial_r <= 32'h0000_0000;
        end else if (!booted_r && nv_valid_i) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
            if (boot_cnt_r == 2'h2) begin
                booted_r <= 1'b1;
                alias_r <= nv_alias_i;
                serial_r <= nv_serial_i;
                sii_err_r <= (nv_magic_i != SENP_SII_MAGIC);
                if (sw_s2_r == 8'h00) begin
                    sw_setup_r <= 1'b1;
                    node_addr_r <= nv_alias_i;
                end else begin
                    sw_setup_r <= 1'b0;
                    node_addr_r <= {8'h00, sw_s2_r};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // station address register
    // ------------------------------------------------------------
    logic [15:0] station_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            station_r <= SENP_STATION_RST;
        end else if (reg_wr_i && reg_addr_i == ADDR_W'(SENP_OFS_STATION)) begin
            station_r <= reg_wdata_i; // master copies alias here
        end
    end

    // read data registered; unmapped and alias writes are ignored
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == ADDR_W'(SENP_OFS_STATION)) begin
                reg_rdata_o <= station_r;
            end else if (reg_addr_i == ADDR_W'(SENP_OFS_ALIAS)) begin
                reg_rdata_o <= alias_r;
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // diagnosis flags
    // ------------------------------------------------------------
    // held only in flops, so every power-on starts disabled
    logic [7:0] diag_flags_r;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            diag_flags_r <= SENP_DIAG_RST;
        end else if (diag_wr_i) begin
            diag_flags_r <= diag_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // emergency request
    // ------------------------------------------------------------
    logic tx_busy;
    logic emcy_go;
    logic [15:0] emcy_code;
    logic [15:0] err_status_r;
    logic emcy_drop_r;
    // a non-communication fault arriving while a message is still leaving is dropped and
    // flagged: no queue, one message in flight at a time
    always_comb begin
        emcy_code = {SENP_CODE_HI, fault_num};
        emcy_go = fault_rise && !fault_comm
                  && (diag_flags_r != 8'h00)
                  && !tx_busy;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            err_status_r <= 16'h0000;
            emcy_drop_r <= 1'b0;
        end else begin
            if (sii_err_r) begin
                err_status_r <= {8'h88, 4'h0, SENP_SII_CHK_CODE};
            end else if (fault_rise) begin
                err_status_r <= emcy_code;
            end
            emcy_drop_r <= fault_rise && !fault_comm
                           && (diag_flags_r != 8'h00) && tx_busy;
        end
    end

    senp_emcy_tx u_tx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(emcy_go),
        .code_i(emcy_code),
        .err_reg_i(err_reg_i),
        .busy_o(tx_busy),
        .mb_data_o(mb_data_o),
        .mb_valid_o(mb_valid_o),
        .mb_last_o(mb_last_o),
        .mb_ready_i(mb_ready_i)
    );

    // ------------------------------------------------------------
    // status outputs straight from flops
    // ------------------------------------------------------------
    assign err_status_o = err_status_r;
    assign serial_o = serial_r;
    assign sw_setup_o = sw_setup_r;
    assign node_addr_o = node_addr_r;
    assign sii_err_o = sii_err_r;
    assign emcy_drop_o = emcy_drop_r;
endmodule

// [senp_pkg.sv]
// package for the slave emergency and node address block
// assumes one 20 MHz clock and a synchronous active-high reset
package senp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] SENP_OFS_STATION = 16'h0010;
    localparam logic [15:0] SENP_OFS_ALIAS = 16'h0012;
    localparam logic [15:0] SENP_STATION_RST = 16'h0000;
    // ------------------------------------------------------------
    // emergency payload
    // ------------------------------------------------------------
    localparam int SENP_EMCY_BYTES = 8;
    localparam logic [7:0] SENP_CODE_HI = 8'hFF;
    localparam logic [7:0] SENP_RSVD_BYTE = 8'h00;
    localparam logic [7:0] SENP_DIAG_RST = 8'h00;
    // ------------------------------------------------------------
    // slave information check
    // ------------------------------------------------------------
    localparam logic [15:0] SENP_SII_MAGIC = 16'hA55A; // arbitrary value
    localparam logic [3:0] SENP_SII_CHK_CODE = 4'h3;
    typedef enum logic [1:0] {
        SENP_IDLE = 2'b00,
        SENP_SEND = 2'b01,
        SENP_DONE = 2'b11
    } senp_state_t;
endpackage

// [senp_emcy_tx.sv]
// serialiser for one eight-byte emergency message
// assumes the mailbox sink takes a byte on each cycle it is ready
`timescale 1ns/10ps
module senp_emcy_tx
    import senp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // message request
    input wire logic start_i,
    input wire logic [15:0] code_i,
    input wire logic [7:0] err_reg_i,
    output logic busy_o,
    // byte stream toward the mailbox
    output logic [7:0] mb_data_o,
    output logic mb_valid_o,
    output logic mb_last_o,
    input wire logic mb_ready_i
);
    senp_state_t state_r;
    logic [2:0] idx_r;
    logic [15:0] code_r;
    logic [7:0] ereg_r;
    logic [7:0] data_r;
    logic valid_r;
    logic last_r;

    // pick the payload byte for a given position
    function automatic logic [7:0] pick(input logic [2:0] i,
                                         input logic [15:0] c,
                                         input logic [7:0] e);
        case (i)
            3'h0: pick = c[7:0];  // low byte first
            3'h1: pick = c[15:8];
            3'h2: pick = e;
            default: pick = SENP_RSVD_BYTE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // request is latched so the source may change while the bytes go out
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= SENP_IDLE;
            idx_r <= 3'h0;
            code_r <= 16'h0000;
            ereg_r <= 8'h00;
        end else begin
            unique case (state_r)
                SENP_IDLE: begin
                    if (start_i) begin
                        state_r <= SENP_SEND;
                        idx_r <= 3'h0;
                        code_r <= code_i;
                        ereg_r <= err_reg_i;
                    end
                end
                SENP_SEND: begin
                    if (mb_ready_i) begin
                        if (idx_r == 3'(SENP_EMCY_BYTES - 1)) begin
                            state_r <= SENP_DONE;
                        end
                        idx_r <= idx_r + 3'h1;
                    end
                end
                SENP_DONE: state_r <= SENP_IDLE;
                default: state_r <= SENP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // stream output flops
    // ------------------------------------------------------------
    // the next byte is loaded as the current one is taken, so the stream
    // pins leave the top straight from flops at no cost in throughput
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            valid_r <= 1'b0;
            data_r <= 8'h00;
            last_r <= 1'b0;
        end else if (state_r == SENP_IDLE && start_i) begin
            valid_r <= 1'b1;
            data_r <= pick(3'h0, code_i, err_reg_i);
            last_r <= 1'b0;
        end else if (valid_r && mb_ready_i) begin
            if (last_r) begin
                valid_r <= 1'b0;
                data_r <= 8'h00;
                last_r <= 1'b0;
            end else begin
                data_r <= pick(idx_r + 3'h1, code_r, ereg_r);
                last_r <= (idx_r + 3'h1 == 3'(SENP_EMCY_BYTES - 1));
            end
        end
    end

    // valid tracks the send state exactly; busy also covers the gap cycle
    assign mb_valid_o = valid_r;
    assign mb_data_o = data_r;
    assign mb_last_o = last_r;
    assign busy_o = (state_r != SENP_IDLE);
endmodule

// [senp_top_asserts.sv]
// port assertions for the emergency and node address block
// assumes it is bound into senp_top and sees only that module's ports
`timescale 1ns/10ps
module senp_top_asserts
    import senp_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // watched inputs
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic diag_wr_i,
    input wire logic [7:0] diag_wdata_i,
    input wire logic [15:0] nv_alias_i,
    input wire logic mb_ready_i,
    // watched outputs
    input wire logic [15:0] reg_rdata_o,
    input wire logic [7:0] mb_data_o,
    input wire logic mb_valid_o,
    input wire logic mb_last_o,
    input wire logic [15:0] err_status_o,
    input wire logic sw_setup_o,
    input wire logic [15:0] node_addr_o,
    input wire logic sii_err_o,
    input wire logic emcy_drop_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] flags_r;
    logic [2:0] pos_r;
    // shadow flags, since the block keeps them internally
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            flags_r <= 8'h00;
        else if (diag_wr_i)
            flags_r <= diag_wdata_i;
    end
    // byte position in the message, wraps to zero after byte seven
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)
            pos_r <= 3'h0;
        else if (mb_valid_o && mb_ready_i)
            pos_r <= pos_r + 3'h1;
    end
    a_last_pos: assert property (mb_last_o |->
        mb_valid_o && pos_r == 3'h7) else $error("last flag off byte seven");
    a_byte_hold: assert property (mb_valid_o && !mb_ready_i |=>
        mb_valid_o && $stable(mb_data_o)) else $error("byte not held");
    a_flags_gate: assert property ($rose(mb_valid_o) |->
        flags_r != 8'h00 && pos_r == 3'h0) else $error("message while off");
    a_code_high: assert property (mb_valid_o && pos_r == 3'h1 |->
        mb_data_o == SENP_CODE_HI) else $error("code high byte wrong");
    a_rsvd_zero: assert property (mb_valid_o && pos_r > 3'h2 |->
        mb_data_o == SENP_RSVD_BYTE) else $error("reserved byte set");
    a_alias_read: assert property (reg_rd_i &&
        reg_addr_i == SENP_OFS_ALIAS |=> reg_rdata_o == nv_alias_i)
        else $error("alias read wrong");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i !=
        SENP_OFS_ALIAS && reg_addr_i != SENP_OFS_STATION |=>
        reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_setup_addr: assert property (sw_setup_o |->
        node_addr_o == nv_alias_i) else $error("setup address wrong");
    // status register follows the check flag one cycle later
    a_sii_code: assert property (sii_err_o |=>
        err_status_o == 16'h8803) else $error("check error code wrong");
    a_drop_pulse: assert property (emcy_drop_o |=> !emcy_drop_o)
        else $error("drop pulse too long");
endmodule

bind senp_top senp_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .diag_wr_i(diag_wr_i), .diag_wdata_i(diag_wdata_i),
    .nv_alias_i(nv_alias_i), .mb_ready_i(mb_ready_i),
    .reg_rdata_o(reg_rdata_o), .mb_data_o(mb_data_o),
    .mb_valid_o(mb_valid_o), .mb_last_o(mb_last_o),
    .err_status_o(err_status_o), .sw_setup_o(sw_setup_o),
    .node_addr_o(node_addr_o), .sii_err_o(sii_err_o),
    .emcy_drop_o(emcy_drop_o));

// [senp_mbox_sink.sv]
// mailbox sink standing in for the bus master side
// assumes the block's byte stream; slow_i stalls every other cycle
`timescale 1ns/10ps
module senp_mbox_sink (
    // clock, reset and pacing
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    // byte stream
    input wire logic [7:0] mb_data_i,
    input wire logic mb_valid_i,
    input wire logic mb_last_i,
    output logic mb_ready_o,
    // gathered message
    output logic [63:0] msg_o,
    output logic [3:0] len_o,
    output logic [7:0] msg_cnt_o
);
    logic [3:0] pos_r;
    // bytes land least significant first; length counted up to the last
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mb_ready_o <= 1'b0;
            pos_r <= 4'h0;
            len_o <= 4'h0;
            msg_cnt_o <= 8'h00;
        end else begin
            mb_ready_o <= slow_i ? ~mb_ready_o : 1'b1;
            if (mb_valid_i && mb_ready_o) begin
                msg_o[8*pos_r[2:0] +: 8] <= mb_data_i;
                pos_r <= pos_r + 4'h1;
                if (mb_last_i) begin
                    len_o <= pos_r + 4'h1;
                    pos_r <= 4'h0;
                    msg_cnt_o <= msg_cnt_o + 8'h01;
                end
            end
        end
    end
endmodule

// [test_senp_top.sv]
// self-checking bench for the emergency and node address block
// assumes the sink model and the bound checker are compiled alongside
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_senp_top
    import senp_pkg::*;
;
    logic clk_i = 0, sys_rst_i = 1, fault_stb_i = 0, fault_is_comm_i = 0;
    logic nv_valid_i = 1, reg_wr_i = 0, reg_rd_i = 0, diag_wr_i = 0;
    logic slow = 0, mb_ready_i, mb_valid_o, mb_last_o, emcy_drop_o;
    logic [7:0] node_sw_i = 8'h00, fault_num_i = 8'h00, err_reg_i = 8'h81;
    logic [7:0] diag_wdata_i = 8'h00, mb_data_o, cnt;
    logic [15:0] nv_alias_i = 16'h1234, nv_magic_i = 16'h0000;
    logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o, err_status_o, node_addr_o;
    logic [31:0] nv_serial_i = 32'h5EC00001, serial_o;
    logic sw_setup_o, sii_err_o;
    logic [63:0] msg;
    logic [3:0] len;
    int mismatches = 0, total_checks = 0, drops = 0, cyc = 0;
    senp_top dut (.clk_i, .sys_rst_i, .node_sw_i, .fault_stb_i,
        .fault_is_comm_i, .fault_num_i, .err_reg_i, .nv_alias_i, .nv_magic_i,
        .nv_serial_i, .nv_valid_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .diag_wr_i, .diag_wdata_i, .mb_data_o,
        .mb_valid_o, .mb_last_o, .mb_ready_i, .err_status_o, .serial_o,
        .sw_setup_o, .node_addr_o, .sii_err_o, .emcy_drop_o);
    senp_mbox_sink u_sink (.clk_i, .sys_rst_i, .slow_i(slow),
        .mb_data_i(mb_data_o), .mb_valid_i(mb_valid_o), .mb_last_i(mb_last_o),
        .mb_ready_o(mb_ready_i), .msg_o(msg), .len_o(len), .msg_cnt_o(cnt));
    initial forever #25 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask
    // strobe held four cycles so the two-flop sync sees each edge
    task automatic fault(input logic c, input logic [7:0] n);
        @(posedge clk_i);
        fault_is_comm_i <= c;
        fault_num_i <= n;
        fault_stb_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        fault_stb_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic power(input logic [7:0] sw, input logic [15:0] mg);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        node_sw_i <= sw;
        nv_magic_i <= mg;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    // drop pulses are tallied; a hang is cut short
    always @(posedge clk_i) begin
        cyc++;
        if (emcy_drop_o === 1'b1) drops++;
        if (cyc == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        power(8'h00, SENP_SII_MAGIC);
        `CHK({sw_setup_o, node_addr_o}, {1'b1, 16'h1234})
        `CHK(serial_o, 32'h5EC00001)
        `CHK(sii_err_o, 1'b0)
        rd(SENP_OFS_ALIAS, 16'h1234);
        rd(SENP_OFS_STATION, SENP_STATION_RST);
        wr(SENP_OFS_ALIAS, 16'hBEEF);
        wr(SENP_OFS_STATION, 16'h1234);
        rd(SENP_OFS_STATION, 16'h1234);
        rd(SENP_OFS_ALIAS, 16'h1234);
        rd(16'h0014, 16'h0000);
        fault(1'b0, 8'h11);
        repeat (30) @(posedge clk_i);
        `CHK(cnt, 8'h00)
        `CHK(err_status_o, 16'hFF11)
        @(posedge clk_i);
        diag_wr_i <= 1'b1;
        diag_wdata_i <= 8'h01;
        @(posedge clk_i);
        diag_wr_i <= 1'b0;
        fault(1'b1, 8'h22);
        repeat (30) @(posedge clk_i);
        `CHK(cnt, 8'h00)
        slow <= 1'b1;
        fault(1'b0, 8'h5A);
        fault(1'b0, 8'h33);
        repeat (60) @(posedge clk_i);
        `CHK({cnt, len}, {8'h01, 4'h8})
        `CHK(msg, 64'h0000_0000_0081_FF5A)
        `CHK(drops, 1)
        // status shows the latest fault even when its message was dropped
        `CHK(err_status_o, 16'hFF33)
        slow <= 1'b0;
        fault(1'b0, 8'h00);
        repeat (40) @(posedge clk_i);
        `CHK({cnt, msg}, {8'h02, 64'h0000_0000_0081_FF00})
        power(8'h2A, 16'h0000);
        `CHK({sw_setup_o, node_addr_o}, {1'b0, 16'h002A})
        `CHK({sii_err_o, err_status_o}, {1'b1, 16'h8803})
        fault(1'b0, 8'h44);
        repeat (40) @(posedge clk_i);
        `CHK(cnt, 8'h00)
        end_sim();
    end
endmodule
